// *** mis_pkg.sv ***
// Purpose: shared constants and carriers for the MAC interrupt mask and station address slice
// Assumes: registers are 32-bit words on an Avalon-MM slave, byte addressed
// Notes:   bit n in big-endian register numbering (0 = msb) lands on hardware bit 31-n
package mis_pkg;

  function automatic int unsigned mis_be_bit(input int unsigned n);
    return 31 - n;
  endfunction

  localparam logic [4:0] MIS_ADDR_W = 5'h05;

  // register byte offsets
  localparam logic [4:0] MIS_OFS_STATUS  = 5'h00;
  localparam logic [4:0] MIS_OFS_IRQ_EN  = 5'h04;
  localparam logic [4:0] MIS_OFS_ADDR_HI = 5'h08;
  localparam logic [4:0] MIS_OFS_ADDR_LO = 5'h0C;
  localparam logic [4:0] MIS_OFS_RX_CTRL = 5'h10;

  // status field positions (hardware bit index)
  localparam int unsigned MIS_BIT_OVERRUN      = mis_be_bit(6);
  localparam int unsigned MIS_BIT_PAUSE_FRAME  = mis_be_bit(7);
  localparam int unsigned MIS_BIT_BAD_FRAME    = mis_be_bit(8);
  localparam int unsigned MIS_BIT_RUNT_FRAME   = mis_be_bit(9);
  localparam int unsigned MIS_BIT_SHORT_EVENT  = mis_be_bit(10);
  localparam int unsigned MIS_BIT_ALIGN_ERR    = mis_be_bit(11);
  localparam int unsigned MIS_BIT_CRC_FAIL     = mis_be_bit(12);
  localparam int unsigned MIS_BIT_TOO_LONG     = mis_be_bit(13);
  localparam int unsigned MIS_BIT_LEN_BEYOND   = mis_be_bit(14);
  localparam int unsigned MIS_BIT_LEN_IN_RANGE = mis_be_bit(15);
  localparam int unsigned MIS_BIT_DEP_DEAD     = mis_be_bit(22);
  localparam int unsigned MIS_BIT_CH0_DEAD     = mis_be_bit(23);
  localparam int unsigned MIS_BIT_SQE_CH0      = mis_be_bit(24);
  localparam int unsigned MIS_BIT_TX_ABORT_CH0 = mis_be_bit(25);
  localparam int unsigned MIS_BIT_CH1_DEAD     = mis_be_bit(26);
  localparam int unsigned MIS_BIT_SQE_CH1      = mis_be_bit(27);
  localparam int unsigned MIS_BIT_TX_ABORT_CH1 = mis_be_bit(28);
  localparam int unsigned MIS_BIT_PHY_MGMT_OK  = mis_be_bit(30);
  localparam int unsigned MIS_BIT_PHY_MGMT_ERR = mis_be_bit(31);

  // implemented enable bits, and status bits (enables plus the dead flags)
  localparam logic [31:0] MIS_IRQ_EN_IMPL = 32'h03FF_00DB;
  localparam logic [31:0] MIS_DEAD_BITS   = 32'h0000_0320;
  localparam logic [31:0] MIS_STATUS_IMPL = 32'h03FF_03FB;
  localparam logic [31:0] MIS_ADDR_HI_IMPL = 32'h0000_FFFF;

  localparam int unsigned MIS_BIT_MATCH_EN = 0;

  // reset values
  localparam logic [31:0] MIS_RST_IRQ_EN  = 32'h0000_0000;
  localparam logic [31:0] MIS_RST_STATUS  = 32'h0000_0000;
  localparam logic [47:0] MIS_RST_STATION = 48'h0000_0000_0000;

  localparam logic [1:0] MIS_RESP_OKAY   = 2'h0;
  localparam logic [1:0] MIS_RESP_DECERR = 2'h3;

  typedef struct packed {
    logic        valid;
    logic [47:0] dest;
  } mis_rx_dest_s;

  typedef struct packed {
    logic deliver;
    logic matched;
  } mis_rx_result_s;

endpackage

// *** mis_irq_combine.sv ***
// Purpose: folds status flags and their enables into one interrupt level
// Assumes: status and enable share one bit layout
// Notes:   output is registered, one cycle behind the flags
`timescale 1ns/10ps
module mis_irq_combine (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic [31:0] status,
  input  wire logic [31:0] enable,
  output logic             irq
);

  logic irq_reg;

  // dead flags have no enable position, so they are masked out here too
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(status & enable & mis_pkg::MIS_IRQ_EN_IMPL);
    end
  end

  assign irq = irq_reg;

endmodule

// *** mis_addr_match.sv ***
// Purpose: compares received destination addresses with the station address
// Assumes: one destination offered per valid pulse
// Notes:   result pulse comes one cycle after the offer
`timescale 1ns/10ps
module mis_addr_match (
  input  wire logic                    mclk,
  input  wire logic                    rst_n,
  input  wire logic                    match_en,
  input  wire logic [47:0]             station,
  input  wire mis_pkg::mis_rx_dest_s   rx_in,
  output mis_pkg::mis_rx_result_s      rx_out
);

  mis_pkg::mis_rx_result_s res_reg;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      res_reg <= '0;
    end else begin
      res_reg.deliver <= rx_in.valid && match_en && (rx_in.dest == station);
      if (rx_in.valid) begin
        res_reg.matched <= match_en && (rx_in.dest == station);
      end
    end
  end

  assign rx_out = res_reg;

endmodule

// *** mis_mac_regs.sv ***
// Purpose: interrupt enable mask, status flags and station address registers of the MAC
// Assumes: Avalon-MM slave with waitrequest, every access answered on its second edge
// Notes:   big-endian field numbering is mapped so that bit n sits on hardware bit 31-n
//
// How it works
// - each enable bit pairs with the status flag at the same position
// - enable one with its flag set raises the interrupt
// - enable zero keeps that flag from raising the interrupt
// - enables at reserved positions ignore writes and read zero
// - bits 6, 7, 8 gate overrun, pause frame, bad frame
// - bits 9, 10, 11 gate runt, short event, alignment error
// - bits 12, 13 gate crc failure and oversized frame
// - bits 14, 15 gate length beyond range and in-range length error
// - bits 24, 25 gate channel 0 sqe failure and transmit abort
// - bits 27, 28 gate channel 1 sqe failure and transmit abort
// - bits 30, 31 gate phy management success and failure
// - with matching on, the 48-bit address is compared with each destination
// - a matching frame is handed to the memory access layer
// - the station address is the transmit source and pause frame source
// - high register keeps address bits 0 to 15 in its low half
// - low register keeps the low 32 address bits
// - dead flags never drive the interrupt
`timescale 1ns/10ps
module mis_mac_regs (
  input  wire logic                    mclk,
  input  wire logic                    rst_n,
  input  wire logic [4:0]              avs_address,
  input  wire logic                    avs_read,
  input  wire logic                    avs_write,
  input  wire logic [31:0]             avs_writedata,
  input  wire logic [3:0]              avs_byteenable,
  output logic      [31:0]             avs_readdata,
  output logic      [1:0]              avs_response,
  output logic                         avs_waitrequest,
  input  wire logic [31:0]             status_events,
  input  wire mis_pkg::mis_rx_dest_s   rx_dest,
  output mis_pkg::mis_rx_result_s      memory_access_layer,
  output logic      [47:0]             tx_source_addr,
  output logic                         station_addr_match_enable,
  output logic                         mac_interrupt_out
);

  logic [31:0] irq_en_reg;
  logic [31:0] status_reg;
  logic [47:0] station_reg;
  logic        match_en_reg;
  logic        ack_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  resp_reg;
  logic        wr_take;
  logic        rd_load;
  logic [31:0] status_clr;
  logic [31:0] hi_merge;

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic addr_known(input logic [4:0] a);
    return (a == mis_pkg::MIS_OFS_STATUS) || (a == mis_pkg::MIS_OFS_IRQ_EN) ||
           (a == mis_pkg::MIS_OFS_ADDR_HI) || (a == mis_pkg::MIS_OFS_ADDR_LO) ||
           (a == mis_pkg::MIS_OFS_RX_CTRL);
  endfunction

  // the request is held one cycle so that read data stand at the accepting edge
  assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
  assign wr_take         = avs_write && ack_reg;
  assign rd_load         = avs_read && !ack_reg;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read || avs_write) && !ack_reg;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_en_reg <= mis_pkg::MIS_RST_IRQ_EN;
    end else if (wr_take && avs_address == mis_pkg::MIS_OFS_IRQ_EN) begin
      irq_en_reg <= be_merge(irq_en_reg, avs_writedata, avs_byteenable)
                    & mis_pkg::MIS_IRQ_EN_IMPL;
    end
  end

  // write-one-to-clear; a flag raised in the clearing cycle survives
  always_comb begin
    status_clr = '0;
    if (wr_take && avs_address == mis_pkg::MIS_OFS_STATUS) begin
      status_clr = be_merge(32'h0000_0000, avs_writedata, avs_byteenable);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      status_reg <= mis_pkg::MIS_RST_STATUS;
    end else begin
      status_reg <= ((status_reg & ~status_clr) | status_events) & mis_pkg::MIS_STATUS_IMPL;
    end
  end

  // only the low halfword of the high register is kept, upper lanes fall away
  assign hi_merge = be_merge({16'h0000, station_reg[47:32]}, avs_writedata, avs_byteenable);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      station_reg <= mis_pkg::MIS_RST_STATION;
    end else if (wr_take && avs_address == mis_pkg::MIS_OFS_ADDR_HI) begin
      station_reg[47:32] <= hi_merge[15:0];
    end else if (wr_take && avs_address == mis_pkg::MIS_OFS_ADDR_LO) begin
      station_reg[31:0] <= be_merge(station_reg[31:0], avs_writedata, avs_byteenable);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      match_en_reg <= 1'b0;
    end else if (wr_take && avs_address == mis_pkg::MIS_OFS_RX_CTRL && avs_byteenable[0]) begin
      match_en_reg <= avs_writedata[mis_pkg::MIS_BIT_MATCH_EN];
    end
  end

  // read data captured on the first edge and held through the accepting one
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= '0;
      resp_reg  <= mis_pkg::MIS_RESP_OKAY;
    end else if (rd_load || (avs_write && !ack_reg)) begin
      resp_reg <= addr_known(avs_address) ? mis_pkg::MIS_RESP_OKAY : mis_pkg::MIS_RESP_DECERR;
      if (rd_load) begin
        case (avs_address)
          mis_pkg::MIS_OFS_STATUS:  rdata_reg <= status_reg;
          mis_pkg::MIS_OFS_IRQ_EN:  rdata_reg <= irq_en_reg & mis_pkg::MIS_IRQ_EN_IMPL;
          mis_pkg::MIS_OFS_ADDR_HI: rdata_reg <= {16'h0000, station_reg[47:32]};
          mis_pkg::MIS_OFS_ADDR_LO: rdata_reg <= station_reg[31:0];
          mis_pkg::MIS_OFS_RX_CTRL: rdata_reg <= {31'h0000_0000, match_en_reg};
          default:                  rdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign avs_readdata              = rdata_reg;
  assign avs_response              = resp_reg;
  assign tx_source_addr            = station_reg;
  assign station_addr_match_enable = match_en_reg;

  mis_irq_combine u_irq (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .status (status_reg),
    .enable (irq_en_reg),
    .irq    (mac_interrupt_out)
  );

  mis_addr_match u_match (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .match_en (match_en_reg),
    .station  (station_reg),
    .rx_in    (rx_dest),
    .rx_out   (memory_access_layer)
  );

  // checks
  a_reserved_en_zero: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (irq_en_reg & ~mis_pkg::MIS_IRQ_EN_IMPL) == 32'h0000_0000)
    else $error("reserved enable bit holds a one");

  a_irq_pair_or: assert property (
    @(posedge mclk) disable iff (!rst_n)
    ##1 mac_interrupt_out == |($past(status_reg) & $past(irq_en_reg)))
    else $error("interrupt differs from or of enabled flags");

  a_enabled_raises: assert property (
    @(posedge mclk) disable iff (!rst_n)
    ((status_events & irq_en_reg & mis_pkg::MIS_IRQ_EN_IMPL) != 0) && !wr_take |-> ##2 mac_interrupt_out)
    else $error("enabled event did not raise interrupt");

  a_masked_quiet: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (status_reg & irq_en_reg) == 32'h0000_0000 |=> !mac_interrupt_out)
    else $error("interrupt without an enabled flag");

  a_dead_no_irq: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (status_reg & ~mis_pkg::MIS_DEAD_BITS & irq_en_reg) == 32'h0000_0000 |=> !mac_interrupt_out)
    else $error("dead flag drove the interrupt");

  a_overrun_pair: assert property (
    @(posedge mclk) disable iff (!rst_n)
    status_reg[mis_pkg::MIS_BIT_OVERRUN] && irq_en_reg[mis_pkg::MIS_BIT_OVERRUN] |=> mac_interrupt_out)
    else $error("overrun enable does not gate overrun flag");

  a_phy_fail_pair: assert property (
    @(posedge mclk) disable iff (!rst_n)
    status_reg[mis_pkg::MIS_BIT_PHY_MGMT_ERR] && irq_en_reg[mis_pkg::MIS_BIT_PHY_MGMT_ERR] |=> mac_interrupt_out)
    else $error("phy failure enable does not gate its flag");

  a_status_set_wins: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (status_events & mis_pkg::MIS_STATUS_IMPL) != 0 |=>
      (status_reg & $past(status_events)) == $past(status_events & mis_pkg::MIS_STATUS_IMPL))
    else $error("status event lost");

  a_match_deliver: assert property (
    @(posedge mclk) disable iff (!rst_n)
    rx_dest.valid && match_en_reg && rx_dest.dest == station_reg |=> memory_access_layer.deliver)
    else $error("matching frame not delivered");

  a_no_match_drop: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !(rx_dest.valid && match_en_reg) |=> !memory_access_layer.deliver)
    else $error("frame delivered without match");

  a_hi_read_low: assert property (
    @(posedge mclk) disable iff (!rst_n)
    rd_load && avs_address == mis_pkg::MIS_OFS_ADDR_HI |=> avs_readdata == {16'h0000, $past(station_reg[47:32])})
    else $error("high address read wrong");

  a_lo_write_read: assert property (
    @(posedge mclk) disable iff (!rst_n)
    wr_take && avs_address == mis_pkg::MIS_OFS_ADDR_LO && avs_byteenable == 4'hF |=>
      tx_source_addr[31:0] == $past(avs_writedata))
    else $error("low address write lost");

  a_wait_one: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (avs_read || avs_write) && !ack_reg |=> ack_reg)
    else $error("access not answered on second edge");

endmodule

// *** tb_top.sv ***
// Purpose: self-checking bench for the mac interrupt mask and station address slice
// Assumes: bus accesses answered after a wait state, interrupt output registered
// Notes:   each scenario judges its own results before returning
`timescale 1ns/10ps
module tb_top;
  logic                    mclk;
  logic                    rst_n;
  logic [4:0]              avs_address;
  logic                    avs_read;
  logic                    avs_write;
  logic [31:0]             avs_writedata;
  logic [3:0]              avs_byteenable;
  logic [31:0]             avs_readdata;
  logic [1:0]              avs_response;
  logic                    avs_waitrequest;
  logic [31:0]             status_events;
  mis_pkg::mis_rx_dest_s   rx_dest;
  mis_pkg::mis_rx_result_s memory_access_layer;
  logic [47:0]             tx_source_addr;
  logic                    station_addr_match_enable;
  logic                    mac_interrupt_out;
  int                      error_cnt = 0;
  int                      n_checks = 0;
  int                      cyc = 0;
  logic [31:0]             rd;
  logic [1:0]              rsp;

  mis_mac_regs mis_mac_regs_i (
    .mclk                      (mclk),
    .rst_n                     (rst_n),
    .avs_address               (avs_address),
    .avs_read                  (avs_read),
    .avs_write                 (avs_write),
    .avs_writedata             (avs_writedata),
    .avs_byteenable            (avs_byteenable),
    .avs_readdata              (avs_readdata),
    .avs_response              (avs_response),
    .avs_waitrequest           (avs_waitrequest),
    .status_events             (status_events),
    .rx_dest                   (rx_dest),
    .memory_access_layer       (memory_access_layer),
    .tx_source_addr            (tx_source_addr),
    .station_addr_match_enable (station_addr_match_enable),
    .mac_interrupt_out         (mac_interrupt_out)
  );

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // whole run is near 800 cycles; the ceiling leaves ample slack
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      error_cnt++;
      finish_test();
    end
  end

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // request held until waitrequest is sampled low at a rising edge
  // only the run ceiling ends a wait that never gets its answer
  task automatic bus_write(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge mclk);
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    avs_write      <= 1'b1;
    do begin
      @(posedge mclk);
    end while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask

  task automatic bus_read(input logic [4:0] a);
    @(posedge mclk);
    avs_address <= a;
    avs_read    <= 1'b1;
    do begin
      @(posedge mclk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    rsp = avs_response;
    avs_read <= 1'b0;
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
    bus_read(a);
    chk(rd, exp);
    chk(rsp, mis_pkg::MIS_RESP_OKAY);
  endtask

  task automatic pulse(input logic [31:0] ev);
    @(posedge mclk);
    status_events <= ev;
    @(posedge mclk);
    status_events <= 32'h0000_0000;
    wait_clk(2);
  endtask

  task automatic rx_offer(input logic [47:0] d, input logic m);
    @(posedge mclk);
    rx_dest <= '{valid: 1'b1, dest: d};
    @(posedge mclk);
    rx_dest <= '{valid: 1'b0, dest: ~d};
    @(posedge mclk);
    chk(memory_access_layer.deliver, m);
    chk(memory_access_layer.matched, m);
    @(posedge mclk);
    chk(memory_access_layer.deliver, 1'b0);
  endtask

  task automatic test_layout;
    rd_chk(mis_pkg::MIS_OFS_IRQ_EN, 32'h0000_0000);
    chk(mac_interrupt_out, 1'b0);
    bus_write(mis_pkg::MIS_OFS_IRQ_EN, 32'hFFFF_FFFF, 4'hF);
    rd_chk(mis_pkg::MIS_OFS_IRQ_EN, mis_pkg::MIS_IRQ_EN_IMPL);
    bus_write(mis_pkg::MIS_OFS_ADDR_HI, 32'hFFFF_A5C3, 4'hF);
    rd_chk(mis_pkg::MIS_OFS_ADDR_HI, 32'h0000_A5C3);
    bus_write(mis_pkg::MIS_OFS_ADDR_LO, 32'h1234_5678, 4'hF);
    rd_chk(mis_pkg::MIS_OFS_ADDR_LO, 32'h1234_5678);
    chk(tx_source_addr, 48'hA5C3_1234_5678);
    // single lane write must leave the upper lanes alone
    bus_write(mis_pkg::MIS_OFS_ADDR_LO, 32'hFFFF_FFFF, 4'h1);
    rd_chk(mis_pkg::MIS_OFS_ADDR_LO, 32'h1234_56FF);
    chk(tx_source_addr, 48'hA5C3_1234_56FF);
    bus_read(5'h14);
    chk(rd, 32'h0000_0000);
    chk(rsp, mis_pkg::MIS_RESP_DECERR);
    $display("test layout done");
  endtask

  task automatic test_irq_bits;
    logic [31:0] m;
    for (int i = 0; i < 32; i++) begin
      m = 32'h0000_0001 << i;
      bus_write(mis_pkg::MIS_OFS_IRQ_EN, ~m, 4'hF);
      pulse(m);
      chk(mac_interrupt_out, 1'b0);
      rd_chk(mis_pkg::MIS_OFS_STATUS, m & mis_pkg::MIS_STATUS_IMPL);
      bus_write(mis_pkg::MIS_OFS_IRQ_EN, m, 4'hF);
      wait_clk(2);
      chk(mac_interrupt_out, mis_pkg::MIS_IRQ_EN_IMPL[i]);
      bus_write(mis_pkg::MIS_OFS_STATUS, m, 4'hF);
      wait_clk(2);
      chk(mac_interrupt_out, 1'b0);
      rd_chk(mis_pkg::MIS_OFS_STATUS, 32'h0000_0000);
    end
    $display("test irq bits done");
  endtask

  task automatic test_irq_or;
    bus_write(mis_pkg::MIS_OFS_IRQ_EN, 32'hFFFF_FFFF, 4'hF);
    pulse(32'h0000_0003);
    chk(mac_interrupt_out, 1'b1);
    bus_write(mis_pkg::MIS_OFS_STATUS, 32'h0000_0001, 4'hF);
    wait_clk(2);
    chk(mac_interrupt_out, 1'b1);
    bus_write(mis_pkg::MIS_OFS_STATUS, 32'h0000_0002, 4'hF);
    wait_clk(2);
    chk(mac_interrupt_out, 1'b0);
    $display("test irq or done");
  endtask

  task automatic test_match;
    rx_offer(48'hA5C3_1234_56FF, 1'b0);
    bus_write(mis_pkg::MIS_OFS_RX_CTRL, 32'h0000_0001, 4'hF);
    // the enable lands at the accepting edge and shows one edge later
    wait_clk(1);
    chk(station_addr_match_enable, 1'b1);
    rx_offer(48'hA5C3_1234_56FF, 1'b1);
    rx_offer(48'hA5C3_1234_56FE, 1'b0);
    rx_offer(48'h25C3_1234_56FF, 1'b0);
    $display("test match done");
  endtask

  initial begin
    rst_n          = 1'b0;
    avs_address    = 5'h00;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h0000_0000;
    avs_byteenable = 4'h0;
    status_events  = 32'h0000_0000;
    rx_dest        = '0;
    wait_clk(5);
    rst_n <= 1'b1;
    test_layout();
    test_irq_bits();
    test_irq_or();
    test_match();
    finish_test();
  end
endmodule
